// [verilog/insn_exec.sv]
// Execution core for branch, transfer, bit and shift instructions
`timescale 1ns/1ps
// Function
// - branch_no_overflow jumps to PC+offset+1 if V is zero; 1 or 2 cycles.
// - branch_irq_on jumps to PC+offset+1 if I is one; 1 or 2 cycles.
// - branch_irq_off jumps to PC+offset+1 if I is zero; 1 or 2 cycles.
// - Post-increment load reads at pointer, writes register, bumps pointer; 2 cycles.
// - Pre-decrement load lowers pointer first, then reads there; 2 cycles.
// - Displaced load reads at X, Y or Z plus displacement, pointer kept; 2 cycles.
// - Direct load reads address from instruction, no flag change; 2 cycles.
// - Post-increment store writes at pointer, then bumps pointer; 2 cycles.
// - Pre-decrement store lowers pointer, then writes there; 2 cycles.
// - Displaced store writes at X, Y or Z plus displacement, pointer kept; 2 cycles.
// - Direct store writes to instruction address, no flag change; 2 cycles.
// - program_memory_read loads byte at Z into R0 or register; 3 cycles.
// - stack_save pushes source register in 2 cycles, flags unchanged.
// - stack_restore pops into destination register in 2 cycles, flags unchanged.
// - io_bit_set and io_bit_clear force one I/O bit; 2 cycles.
// - rotate_left_carry: C into bit 0, bit 7 into C; one cycle.
// - rotate_right_carry: C into bit 7, bit 0 into C; one cycle.
// - copy_bit_to_t copies selected register bit into T only; one cycle.
// - copy_t_to_bit copies T into selected register bit; one cycle.
module insn_exec
  import insn_exec_pkg::*;
(
  // Clock and reset
  input logic clk_in,
  input logic nrst_in,
  // Instruction stream
  input logic insn_valid_in,
  input logic [INSN_W-1:0] insn_in,
  output logic insn_ready_out,
  // Core state
  output logic [ADDR_W-1:0] pc_out,
  output logic [DATA_W-1:0] flags_out,
  // Data memory
  output logic [ADDR_W-1:0] dm_addr_out,
  output logic [DATA_W-1:0] dm_wdata_out,
  output logic dm_re_out,
  output logic dm_we_out,
  input logic [DATA_W-1:0] dm_rdata_in,
  // Program memory
  output logic [ADDR_W-1:0] pm_addr_out,
  output logic pm_re_out,
  input logic [PM_W-1:0] pm_rdata_in,
  // I/O register space
  output logic [IOA_W-1:0] io_addr_out,
  output logic [DATA_W-1:0] io_wdata_out,
  output logic io_re_out,
  output logic io_we_out,
  input logic [DATA_W-1:0] io_rdata_in
);
  // Register file and core state
  logic [DATA_W-1:0] rf_q [REG_CNT];
  logic [ADDR_W-1:0] pc_q;
  logic [DATA_W-1:0] flags_q;
  logic [DATA_W-1:0] flags_d;
  logic [ADDR_W-1:0] sp_q;
  // Sequencer
  state_t st_q;
  logic ready_q;
  logic [1:0] wait_q;
  pend_t pend_q;
  logic [4:0] tgt_q;
  logic io_pend_q;
  logic pm_hi_q;
  logic rmw_set_q;
  logic [2:0] rmw_bit_q;
  // Bus outputs
  logic [ADDR_W-1:0] dm_addr_q;
  logic [DATA_W-1:0] dm_wdata_q;
  logic dm_re_q;
  logic dm_we_q;
  logic [ADDR_W-1:0] pm_addr_q;
  logic pm_re_q;
  logic [IOA_W-1:0] io_addr_q;
  logic [DATA_W-1:0] io_wdata_q;
  logic io_re_q;
  logic io_we_q;
  // Decode
  op_t op;
  logic [4:0] rd;
  logic [4:0] rr;
  logic [15:0] imm;
  logic [2:0] bsel;
  amode_t amode;
  logic [1:0] psel;
  logic accept;
  logic fin;
  logic take;
  logic [1:0] cyc;
  pend_t pend_kind;
  logic early_we;
  logic [DATA_W-1:0] early_data;
  logic late_we;
  logic [DATA_W-1:0] late_data;
  logic [DATA_W-1:0] pm_byte;
  logic [DATA_W-1:0] rd_v;
  logic [DATA_W-1:0] rr_v;
  logic [DATA_W-1:0] plo_v;
  logic [DATA_W-1:0] phi_v;
  logic [4:0] ptr_idx;
  logic [4:0] ptr_hi_idx;
  logic is_ptr;
  logic is_disp;
  logic ptr_we;
  amode_t au_mode;
  logic [ADDR_W-1:0] au_addr;
  logic [ADDR_W-1:0] au_next;
  logic au_we;
  logic [DATA_W-1:0] sh_res;
  logic sh_c;
  logic sh_z;
  logic sh_n;
  logic sh_v;
  logic [ADDR_W-1:0] ofs_ext;

  assign op = op_t'(insn_in[OP_LSB +: 5]);
  assign rd = insn_in[RD_LSB +: 5];
  assign rr = insn_in[RR_LSB +: 5];
  assign imm = insn_in[15:0];
  assign bsel = imm[BSEL_LSB +: 3];
  assign amode = amode_t'(imm[AMODE_LSB +: 2]);
  assign psel = imm[PSEL_LSB +: 2];
  assign accept = insn_valid_in && ready_q;
  assign fin = (st_q == ST_WAIT) && (wait_q == 2'h1);
  assign ofs_ext = {{(ADDR_W - OFS_W){imm[OFS_W-1]}}, imm[OFS_W-1:0]};

  // Pointer pair selection
  always_comb begin
    case (psel)
      2'b00: ptr_idx = REG_X;
      2'b01: ptr_idx = REG_Y;
      default: ptr_idx = REG_Z;
    endcase
    if (op == OP_PM_READ) begin
      ptr_idx = REG_Z;
    end
  end
  assign ptr_hi_idx = ptr_idx + 5'h01;

  // Late write-back of loaded data
  assign pm_byte = pm_hi_q ? pm_rdata_in[15:8] : pm_rdata_in[7:0];
  assign late_we = io_pend_q || (fin && (pend_q == PEND_LOAD || pend_q == PEND_PM));
  assign late_data = io_pend_q ? io_rdata_in :
                     (pend_q == PEND_PM) ? pm_byte : dm_rdata_in;

  // Forwarding keeps a port read usable by the very next instruction
  assign rd_v = (late_we && tgt_q == rd) ? late_data : rf_q[rd];
  assign rr_v = (late_we && tgt_q == rr) ? late_data : rf_q[rr];
  assign plo_v = (late_we && tgt_q == ptr_idx) ? late_data : rf_q[ptr_idx];
  assign phi_v = (late_we && tgt_q == ptr_hi_idx) ? late_data : rf_q[ptr_hi_idx];

  assign is_ptr = (op == OP_PTR_LOAD) || (op == OP_PTR_WRITE);
  assign is_disp = (op == OP_DISP_LOAD) || (op == OP_DISP_WRITE);
  // Program memory reads only know the post-increment form
  assign au_mode = (op == OP_PM_READ && amode != AM_POST) ? AM_PLAIN : amode;
  assign ptr_we = accept && au_we && (is_ptr || op == OP_PM_READ);

  addr_unit u_addr (
    .ptr_in(({phi_v, plo_v})),
    .amode_in(au_mode),
    .disp_en_in(is_disp),
    .disp_in(imm[DISP_W-1:0]),
    .addr_out(au_addr),
    .ptr_next_out(au_next),
    .ptr_we_out(au_we)
  );

  shift_unit u_shift (
    .op_in(op),
    .val_in(rd_v),
    .carry_in(flags_q[FLAG_C]),
    .res_out(sh_res),
    .c_out(sh_c),
    .z_out(sh_z),
    .n_out(sh_n),
    .v_out(sh_v)
  );

  // Decode: cycle count, early result, flag update
  always_comb begin
    take = 1'b0;
    cyc = CYC_ONE;
    pend_kind = PEND_NONE;
    early_we = 1'b0;
    early_data = rd_v;
    flags_d = flags_q;
    case (op)
      OP_BR_NO_OVF: take = ~flags_q[FLAG_V];
      OP_BR_IRQ_ON: take = flags_q[FLAG_I];
      OP_BR_IRQ_OFF: take = ~flags_q[FLAG_I];
      OP_COPY_REG: begin
        early_we = 1'b1;
        early_data = rr_v;
      end
      OP_LOAD_IMM: begin
        early_we = 1'b1;
        early_data = imm[7:0];
      end
      OP_PTR_LOAD, OP_DISP_LOAD, OP_DIRECT_LOAD: begin
        cyc = CYC_MEM;
        pend_kind = PEND_LOAD;
      end
      OP_PTR_WRITE, OP_DISP_WRITE, OP_DIRECT_WRITE: cyc = CYC_MEM;
      OP_STACK_SAVE: cyc = CYC_STACK;
      OP_STACK_RESTORE: begin
        cyc = CYC_STACK;
        pend_kind = PEND_LOAD;
      end
      OP_PM_READ: begin
        cyc = CYC_PM;
        pend_kind = PEND_PM;
      end
      OP_IO_BIT_SET, OP_IO_BIT_CLR: begin
        cyc = CYC_IO_BIT;
        pend_kind = PEND_RMW;
      end
      OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_SHIFT_RIGHT_S, OP_ROT_LEFT, OP_ROT_RIGHT: begin
        early_we = 1'b1;
        early_data = sh_res;
        flags_d[FLAG_C] = sh_c;
        flags_d[FLAG_Z] = sh_z;
        flags_d[FLAG_N] = sh_n;
        flags_d[FLAG_V] = sh_v;
      end
      OP_NIB_SWAP: begin
        early_we = 1'b1;
        early_data = {rd_v[3:0], rd_v[7:4]};
      end
      OP_FLAG_SET: flags_d[bsel] = 1'b1;
      OP_FLAG_CLR: flags_d[bsel] = 1'b0;
      OP_BIT_TO_T: flags_d[FLAG_T] = rd_v[bsel];
      OP_T_TO_BIT: begin
        early_we = 1'b1;
        early_data[bsel] = flags_q[FLAG_T];
      end
      default: begin
      end
    endcase
    if (take) begin
      cyc = CYC_BRANCH_TAKEN;
    end
    if (!accept) begin
      early_we = 1'b0;
      flags_d = flags_q;
    end
  end

  // Sequencer: holds ready low for the extra cycles
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_q <= ST_IDLE;
      ready_q <= 1'b1;
      wait_q <= 2'h0;
      pend_q <= PEND_NONE;
      tgt_q <= 5'h00;
    end else if (st_q == ST_IDLE) begin
      if (accept) begin
        tgt_q <= (op == OP_PM_READ && amode == AM_IMPLICIT) ? REG_IMPLICIT : rd;
      end
      if (accept && cyc != CYC_ONE) begin
        st_q <= ST_WAIT;
        ready_q <= 1'b0;
        wait_q <= cyc - 2'h1;
        pend_q <= pend_kind;
      end
    end else if (fin) begin
      st_q <= ST_IDLE;
      ready_q <= 1'b1;
      pend_q <= PEND_NONE;
    end else begin
      wait_q <= wait_q - 2'h1;
    end
  end

  // Program counter
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc_q <= PC_RST;
    end else if (accept) begin
      pc_q <= take ? (pc_q + ofs_ext + 16'h0001) : (pc_q + 16'h0001);
    end
  end

  // Status flags
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Stack pointer, post-decrement on push
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sp_q <= SP_RST;
    end else if (accept && op == OP_STACK_SAVE) begin
      sp_q <= sp_q - 16'h0001;
    end else if (accept && op == OP_STACK_RESTORE) begin
      sp_q <= sp_q + 16'h0001;
    end
  end

  // Register file; later writes in the block take priority
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < REG_CNT; i++) begin
        rf_q[i] <= 8'h00;
      end
    end else begin
      if (ptr_we) begin
        rf_q[ptr_idx] <= au_next[7:0];
        rf_q[ptr_hi_idx] <= au_next[15:8];
      end
      if (late_we) begin
        rf_q[tgt_q] <= late_data;
      end
      if (early_we) begin
        rf_q[rd] <= early_data;
      end
    end
  end

  // Data memory strobes, one cycle after acceptance
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      dm_addr_q <= 16'h0000;
      dm_wdata_q <= 8'h00;
      dm_re_q <= 1'b0;
      dm_we_q <= 1'b0;
    end else begin
      dm_re_q <= 1'b0;
      dm_we_q <= 1'b0;
      if (accept) begin
        case (op)
          OP_PTR_LOAD, OP_DISP_LOAD: begin
            dm_addr_q <= au_addr;
            dm_re_q <= 1'b1;
          end
          OP_DIRECT_LOAD: begin
            dm_addr_q <= imm;
            dm_re_q <= 1'b1;
          end
          OP_PTR_WRITE, OP_DISP_WRITE: begin
            dm_addr_q <= au_addr;
            dm_wdata_q <= rr_v;
            dm_we_q <= 1'b1;
          end
          OP_DIRECT_WRITE: begin
            dm_addr_q <= imm;
            dm_wdata_q <= rr_v;
            dm_we_q <= 1'b1;
          end
          OP_STACK_SAVE: begin
            dm_addr_q <= sp_q;
            dm_wdata_q <= rr_v;
            dm_we_q <= 1'b1;
          end
          OP_STACK_RESTORE: begin
            dm_addr_q <= sp_q + 16'h0001;
            dm_re_q <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Program memory word fetch; Z bit 0 picks the byte
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pm_addr_q <= 16'h0000;
      pm_re_q <= 1'b0;
      pm_hi_q <= 1'b0;
    end else begin
      pm_re_q <= 1'b0;
      if (accept && op == OP_PM_READ) begin
        pm_addr_q <= {1'b0, au_addr[15:1]};
        pm_hi_q <= au_addr[0];
        pm_re_q <= 1'b1;
      end
    end
  end

  // I/O space access and bit read-modify-write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      io_addr_q <= 6'h00;
      io_wdata_q <= 8'h00;
      io_re_q <= 1'b0;
      io_we_q <= 1'b0;
      io_pend_q <= 1'b0;
      rmw_set_q <= 1'b0;
      rmw_bit_q <= 3'h0;
    end else begin
      io_re_q <= 1'b0;
      io_we_q <= 1'b0;
      io_pend_q <= accept && op == OP_PORT_READ;
      if (accept && (op == OP_PORT_READ || op == OP_IO_BIT_SET || op == OP_IO_BIT_CLR)) begin
        io_addr_q <= imm[IOA_W-1:0];
        io_re_q <= 1'b1;
        rmw_set_q <= (op == OP_IO_BIT_SET);
        rmw_bit_q <= bsel;
      end
      if (accept && op == OP_PORT_WRITE) begin
        io_addr_q <= imm[IOA_W-1:0];
        io_wdata_q <= rr_v;
        io_we_q <= 1'b1;
      end
      if (fin && pend_q == PEND_RMW) begin
        io_wdata_q <= rmw_set_q ? (io_rdata_in | (8'h01 << rmw_bit_q)) :
                                  (io_rdata_in & ~(8'h01 << rmw_bit_q));
        io_we_q <= 1'b1;
      end
    end
  end

  assign insn_ready_out = ready_q;
  assign pc_out = pc_q;
  assign flags_out = flags_q;
  assign dm_addr_out = dm_addr_q;
  assign dm_wdata_out = dm_wdata_q;
  assign dm_re_out = dm_re_q;
  assign dm_we_out = dm_we_q;
  assign pm_addr_out = pm_addr_q;
  assign pm_re_out = pm_re_q;
  assign io_addr_out = io_addr_q;
  assign io_wdata_out = io_wdata_q;
  assign io_re_out = io_re_q;
  assign io_we_out = io_we_q;
endmodule // insn_exec

// [verilog/insn_exec_pkg.sv]
// Constants and types shared by the instruction execution core
package insn_exec_pkg;
  // Widths
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int INSN_W = 32;
  localparam int PM_W = 16;
  localparam int REG_CNT = 32;
  localparam int OFS_W = 7;
  localparam int DISP_W = 6;
  localparam int IOA_W = 6;
  // Instruction word fields
  localparam int OP_LSB = 26;
  localparam int RD_LSB = 21;
  localparam int RR_LSB = 16;
  localparam int PSEL_LSB = 8;
  localparam int AMODE_LSB = 10;
  localparam int BSEL_LSB = 12;
  // Flag positions in flag_register
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;
  // Register numbers of implicit target and pointer pairs
  localparam logic [4:0] REG_IMPLICIT = 5'h00;
  localparam logic [4:0] REG_X = 5'h1a;
  localparam logic [4:0] REG_Y = 5'h1c;
  localparam logic [4:0] REG_Z = 5'h1e;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h00ff;
  // Cycle counts per instruction class
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_BRANCH_TAKEN = 2'h2;
  localparam logic [1:0] CYC_MEM = 2'h2;
  localparam logic [1:0] CYC_STACK = 2'h2;
  localparam logic [1:0] CYC_IO_BIT = 2'h2;
  localparam logic [1:0] CYC_PM = 2'h3;
  typedef enum logic [4:0] {
    OP_NOP = 5'b00000,
    OP_BR_NO_OVF = 5'b00001,
    OP_BR_IRQ_ON = 5'b00010,
    OP_BR_IRQ_OFF = 5'b00011,
    OP_COPY_REG = 5'b00100,
    OP_LOAD_IMM = 5'b00101,
    OP_PTR_LOAD = 5'b00110,
    OP_DISP_LOAD = 5'b00111,
    OP_DIRECT_LOAD = 5'b01000,
    OP_PTR_WRITE = 5'b01001,
    OP_DISP_WRITE = 5'b01010,
    OP_DIRECT_WRITE = 5'b01011,
    OP_PM_READ = 5'b01100,
    OP_PORT_READ = 5'b01101,
    OP_PORT_WRITE = 5'b01110,
    OP_STACK_SAVE = 5'b01111,
    OP_STACK_RESTORE = 5'b10000,
    OP_IO_BIT_SET = 5'b10001,
    OP_IO_BIT_CLR = 5'b10010,
    OP_SHIFT_LEFT = 5'b10011,
    OP_SHIFT_RIGHT = 5'b10100,
    OP_SHIFT_RIGHT_S = 5'b10101,
    OP_ROT_LEFT = 5'b10110,
    OP_ROT_RIGHT = 5'b10111,
    OP_NIB_SWAP = 5'b11000,
    OP_FLAG_SET = 5'b11001,
    OP_FLAG_CLR = 5'b11010,
    OP_BIT_TO_T = 5'b11011,
    OP_T_TO_BIT = 5'b11100
  } op_t;
  typedef enum logic [1:0] {
    AM_PLAIN = 2'b00,
    AM_POST = 2'b01,
    AM_PRE = 2'b10,
    AM_IMPLICIT = 2'b11
  } amode_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_WAIT = 1'b1
  } state_t;
  typedef enum logic [1:0] {
    PEND_NONE = 2'b00,
    PEND_LOAD = 2'b01,
    PEND_PM = 2'b10,
    PEND_RMW = 2'b11
  } pend_t;
endpackage

// [verilog/shift_unit.sv]
// Shift and rotate datapath with flag results
`timescale 1ns/1ps
module shift_unit
  import insn_exec_pkg::*;
(
  // Operation and operand
  input op_t op_in,
  input logic [DATA_W-1:0] val_in,
  input logic carry_in,
  // Result and flags
  output logic [DATA_W-1:0] res_out,
  output logic c_out,
  output logic z_out,
  output logic n_out,
  output logic v_out
);
  always_comb begin
    res_out = val_in;
    c_out = carry_in;
    case (op_in)
      OP_SHIFT_LEFT: begin
        res_out = {val_in[6:0], 1'b0};
        c_out = val_in[7];
      end
      OP_SHIFT_RIGHT: begin
        res_out = {1'b0, val_in[7:1]};
        c_out = val_in[0];
      end
      OP_SHIFT_RIGHT_S: begin
        res_out = {val_in[7], val_in[7:1]};
        c_out = val_in[0];
      end
      OP_ROT_LEFT: begin
        res_out = {val_in[6:0], carry_in};
        c_out = val_in[7];
      end
      OP_ROT_RIGHT: begin
        res_out = {carry_in, val_in[7:1]};
        c_out = val_in[0];
      end
      default: begin
      end
    endcase
  end
  assign z_out = (res_out == 8'h00);
  assign n_out = res_out[7];
  // Overflow follows N xor C after a shift
  assign v_out = n_out ^ c_out;
endmodule // shift_unit

// [verilog/addr_unit.sv]
// Pointer address generation for indirect and displaced accesses
`timescale 1ns/1ps
module addr_unit
  import insn_exec_pkg::*;
(
  // Pointer and mode
  input logic [ADDR_W-1:0] ptr_in,
  input amode_t amode_in,
  input logic disp_en_in,
  input logic [DISP_W-1:0] disp_in,
  // Access address and pointer update
  output logic [ADDR_W-1:0] addr_out,
  output logic [ADDR_W-1:0] ptr_next_out,
  output logic ptr_we_out
);
  logic [ADDR_W-1:0] dec;
  assign dec = ptr_in - 16'h0001;
  always_comb begin
    addr_out = ptr_in;
    ptr_next_out = ptr_in;
    ptr_we_out = 1'b0;
    if (disp_en_in) begin
      addr_out = ptr_in + {10'h000, disp_in};
    end else if (amode_in == AM_POST) begin
      ptr_next_out = ptr_in + 16'h0001;
      ptr_we_out = 1'b1;
    end else if (amode_in == AM_PRE) begin
      addr_out = dec;
      ptr_next_out = dec;
      ptr_we_out = 1'b1;
    end
  end
endmodule // addr_unit

// [dv/mem_model.sv]
// Behavioural data, program and I/O memories for the core
`timescale 1ns/1ps
module mem_model (
  // Clock
  input logic clk_in,
  // Data memory
  input logic [15:0] dm_addr_in,
  input logic [7:0] dm_wdata_in,
  input logic dm_re_in,
  input logic dm_we_in,
  output logic [7:0] dm_rdata_out,
  // Program memory
  input logic [15:0] pm_addr_in,
  input logic pm_re_in,
  output logic [15:0] pm_rdata_out,
  // I/O space
  input logic [5:0] io_addr_in,
  input logic [7:0] io_wdata_in,
  input logic io_re_in,
  input logic io_we_in,
  output logic [7:0] io_rdata_out
);
  logic [7:0] dm_q [256];
  logic [7:0] io_q [64];
  logic [7:0] junk_q = 8'h5a;
  // Idle lines wander, so stale data never passes
  always @(posedge clk_in) begin
    junk_q <= junk_q + 8'h1d;
    if (dm_we_in) dm_q[dm_addr_in[7:0]] <= dm_wdata_in;
    if (io_we_in) io_q[io_addr_in] <= io_wdata_in;
    pm_rdata_out <= pm_re_in ? {~pm_addr_in[7:0], pm_addr_in[7:0]} : {junk_q, ~junk_q};
  end
  assign dm_rdata_out = dm_re_in ? dm_q[dm_addr_in[7:0]] : junk_q;
  assign io_rdata_out = io_re_in ? io_q[io_addr_in] : ~junk_q;
endmodule // mem_model

// [dv/insn_exec_chk.sv]
// Port assertions for the execution core
`timescale 1ns/1ps
module insn_exec_chk
  import insn_exec_pkg::*;
(
  // Clock and reset
  input logic clk_in,
  input logic nrst_in,
  // Instruction stream and state
  input logic insn_valid_in,
  input logic [INSN_W-1:0] insn_in,
  input logic insn_ready_out,
  input logic [ADDR_W-1:0] pc_out,
  input logic [DATA_W-1:0] flags_out,
  // Strobes and I/O data
  input logic dm_re_out,
  input logic dm_we_out,
  input logic io_re_out,
  input logic io_we_out,
  input logic [DATA_W-1:0] io_wdata_out,
  input logic [DATA_W-1:0] io_rdata_in
);
  op_t op;
  logic acc, tkn;
  logic [ADDR_W-1:0] tgt;
  assign op = op_t'(insn_in[30:26]);
  assign acc = insn_valid_in && insn_ready_out;
  assign tkn = (op==OP_BR_NO_OVF) ? !flags_out[FLAG_V] : (op == OP_BR_IRQ_ON) == flags_out[FLAG_I];
  assign tgt = pc_out + {{9{insn_in[6]}}, insn_in[6:0]} + 16'h0001;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  mem_ready_a:
    assert property (acc && op inside {[OP_PTR_LOAD:OP_DIRECT_WRITE],[OP_STACK_SAVE:OP_IO_BIT_CLR]}
      |=> !insn_ready_out ##1 insn_ready_out) else $error("memory op ready timing wrong");
  pm_ready_a:
    assert property (acc && op == OP_PM_READ |=> !insn_ready_out [*2] ##1 insn_ready_out)
    else $error("program read ready timing wrong");
  one_cycle_a:
    assert property (acc && op inside {OP_COPY_REG, OP_LOAD_IMM, [OP_PORT_READ:OP_PORT_WRITE],
      [OP_SHIFT_LEFT:OP_T_TO_BIT]} |=> insn_ready_out) else $error("one-cycle op stalled");
  br_taken_a:
    assert property (acc && op inside {[OP_BR_NO_OVF:OP_BR_IRQ_OFF]} && tkn
      |=> pc_out == $past(tgt) && !insn_ready_out ##1 insn_ready_out) else $error("taken branch");
  br_skip_a:
    assert property (acc && op inside {[OP_BR_NO_OVF:OP_BR_IRQ_OFF]} && !tkn
      |=> pc_out == $past(pc_out) + 16'h0001 && insn_ready_out) else $error("untaken branch");
  load_strobe_a:
    assert property (acc && op inside {[OP_PTR_LOAD:OP_DIRECT_LOAD], OP_STACK_RESTORE}
      |=> dm_re_out && !dm_we_out ##1 !dm_re_out) else $error("load strobe wrong");
  store_strobe_a:
    assert property (acc && op inside {[OP_PTR_WRITE:OP_DIRECT_WRITE], OP_STACK_SAVE}
      |=> dm_we_out && !dm_re_out ##1 !dm_we_out) else $error("store strobe wrong");
  io_set_a:
    assert property (acc && op == OP_IO_BIT_SET |=> io_re_out ##1 io_we_out
      && io_wdata_out == ($past(io_rdata_in) | (8'h01 << $past(insn_in[14:12], 2))))
    else $error("io bit set wrote wrong byte");
  flags_keep_a:
    assert property (acc && op inside {[OP_COPY_REG:OP_IO_BIT_CLR], OP_NIB_SWAP, OP_T_TO_BIT}
      |=> $stable(flags_out)) else $error("flags changed");
  t_only_a:
    assert property (acc && op == OP_BIT_TO_T
      |=> (flags_out ^ $past(flags_out)) inside {8'h00, 8'h40})
    else $error("bit copy touched other flags");
  flag_set_a:
    assert property (acc && op == OP_FLAG_SET
      |=> flags_out == ($past(flags_out) | (8'h01 << $past(insn_in[14:12]))))
    else $error("flag set");
endmodule // insn_exec_chk
bind insn_exec insn_exec_chk CHK (.clk_in, .nrst_in, .insn_valid_in, .insn_in, .insn_ready_out,
  .pc_out, .flags_out, .dm_re_out, .dm_we_out, .io_re_out, .io_we_out, .io_wdata_out, .io_rdata_in);

// [dv/insn_exec_tb.sv]
// Self-checking bench for the execution core
`timescale 1ns/1ps
module insn_exec_tb
  import insn_exec_pkg::*;
();
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic insn_valid_in = 1'b0;
  logic [31:0] insn_in = 32'h0;
  logic insn_ready_out, dm_re_out, dm_we_out, pm_re_out, io_re_out, io_we_out;
  logic [15:0] pc_out, dm_addr_out, pm_addr_out, pm_rdata_in;
  logic [7:0] flags_out, dm_wdata_out, dm_rdata_in, io_wdata_out, io_rdata_in, v, r;
  logic [5:0] io_addr_out;
  logic [24:0] exp_q [$];
  logic [15:0] pcx = 16'h0;
  logic [6:0] o;
  logic c, nc;
  op_t b;
  op_t sh [6] = '{OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_SHIFT_RIGHT_S, OP_ROT_LEFT, OP_ROT_RIGHT,
    OP_NIB_SWAP};
  int fails = 0, total_checks = 0;
  always #4 clk_in = ~clk_in;
  insn_exec DUT (.clk_in, .nrst_in, .insn_valid_in, .insn_in, .insn_ready_out, .pc_out,
    .flags_out, .dm_addr_out, .dm_wdata_out, .dm_re_out, .dm_we_out, .dm_rdata_in,
    .pm_addr_out, .pm_re_out, .pm_rdata_in, .io_addr_out, .io_wdata_out, .io_re_out,
    .io_we_out, .io_rdata_in);
  mem_model MEM (.clk_in, .dm_addr_in(dm_addr_out), .dm_wdata_in(dm_wdata_out),
    .dm_re_in(dm_re_out), .dm_we_in(dm_we_out), .dm_rdata_out(dm_rdata_in),
    .pm_addr_in(pm_addr_out), .pm_re_in(pm_re_out), .pm_rdata_out(pm_rdata_in),
    .io_addr_in(io_addr_out), .io_wdata_in(io_wdata_out), .io_re_in(io_re_out),
    .io_we_in(io_we_out), .io_rdata_out(io_rdata_in));
  function automatic logic [31:0] mk(op_t p, logic [4:0] d, logic [4:0] s, logic [15:0] i);
    return {1'b0, p, d, s, i};
  endfunction
  task automatic chk(logic [24:0] got, logic [24:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Valid stays up between calls; the next word replaces it at the falling edge
  task automatic run(logic [31:0] w);
    @(negedge clk_in);
    insn_valid_in = 1'b1;
    insn_in = w;
    @(posedge clk_in);
    while (insn_ready_out !== 1'b1) @(posedge clk_in);
    pcx = pcx + 16'h1;
  endtask
  task automatic ex(logic [31:0] w, logic [24:0] e);
    exp_q.push_back(e);
    run(w);
  endtask
  task automatic sd(logic [4:0] s, logic [15:0] a, logic [7:0] d);
    ex(mk(OP_DIRECT_WRITE, 5'h0, s, a), {1'b0, a, d});
  endtask
  task automatic li(logic [4:0] d, logic [7:0] k);
    run(mk(OP_LOAD_IMM, d, 5'h0, {8'h0, k}));
  endtask
  // Monitor pairs each write with the oldest note
  always @(posedge clk_in) begin
    if (dm_we_out === 1'b1 || io_we_out === 1'b1) begin
      if (exp_q.size() == 0) chk(25'h1ffffff, 25'h0);
      else if (io_we_out) chk({1'b1, 10'h0, io_addr_out, io_wdata_out}, exp_q.pop_front());
      else chk({1'b0, dm_addr_out, dm_wdata_out}, exp_q.pop_front());
    end
  end
  // Whole run is a few hundred cycles; this is far beyond it
  initial begin
    #100000;
    fails++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h1bdb9400));
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    nrst_in = 1'b1;
    v = 8'($urandom) & 8'h7e;
    li(5'h10, 8'ha5);
    li(5'h1a, 8'h10);
    li(5'h1b, 8'h00);
    li(5'h1c, 8'h20);
    li(5'h1d, 8'h00);
    li(5'h12, v);
    li(5'h11, 8'h3c);
    sd(5'h10, 16'h0040, 8'ha5);
    ex(mk(OP_PTR_WRITE, 5'h0, 5'h10, 16'h0400), {1'b0, 16'h0010, 8'ha5});
    ex(mk(OP_PTR_WRITE, 5'h0, 5'h11, 16'h0400), {1'b0, 16'h0011, 8'h3c});
    ex(mk(OP_PTR_WRITE, 5'h0, 5'h12, 16'h0800), {1'b0, 16'h0011, v});
    run(mk(OP_PTR_LOAD, 5'h13, 5'h0, 16'h0800));
    run(mk(OP_PTR_LOAD, 5'h14, 5'h0, 16'h0400));
    run(mk(OP_PTR_LOAD, 5'h15, 5'h0, 16'h0000));
    sd(5'h13, 16'h0041, 8'ha5);
    sd(5'h14, 16'h0042, 8'ha5);
    sd(5'h15, 16'h0043, v);
    ex(mk(OP_DISP_WRITE, 5'h0, 5'h12, 16'h0105), {1'b0, 16'h0025, v});
    run(mk(OP_DISP_LOAD, 5'h16, 5'h0, 16'h0105));
    sd(5'h16, 16'h0044, v);
    ex(mk(OP_PTR_WRITE, 5'h0, 5'h10, 16'h0100), {1'b0, 16'h0020, 8'ha5});
    run(mk(OP_DIRECT_LOAD, 5'h17, 5'h0, 16'h0040));
    sd(5'h17, 16'h0045, 8'ha5);
    ex(mk(OP_STACK_SAVE, 5'h0, 5'h10, 16'h0), {1'b0, 16'h00ff, 8'ha5});
    run(mk(OP_STACK_RESTORE, 5'h18, 5'h0, 16'h0));
    sd(5'h18, 16'h0046, 8'ha5);
    run(mk(OP_COPY_REG, 5'h19, 5'h12, 16'h0));
    sd(5'h19, 16'h0047, v);
    $display("transfer test done");
    ex(mk(OP_PORT_WRITE, 5'h0, 5'h10, 16'h0005), {1'b1, 16'h0005, 8'ha5});
    ex(mk(OP_IO_BIT_SET, 5'h0, 5'h0, 16'h1005), {1'b1, 16'h0005, 8'ha7});
    ex(mk(OP_IO_BIT_CLR, 5'h0, 5'h0, 16'h0005), {1'b1, 16'h0005, 8'ha6});
    run(mk(OP_PORT_READ, 5'h15, 5'h0, 16'h0005));
    sd(5'h15, 16'h0048, 8'ha6);
    li(5'h1e, 8'h13);
    li(5'h1f, 8'h00);
    run(mk(OP_PM_READ, 5'h0, 5'h0, 16'h0c00));
    run(mk(OP_PM_READ, 5'h18, 5'h0, 16'h0400));
    run(mk(OP_PM_READ, 5'h19, 5'h0, 16'h0000));
    sd(5'h00, 16'h0049, 8'hf6);
    sd(5'h18, 16'h004a, 8'hf6);
    sd(5'h19, 16'h004b, 8'h0a);
    run(mk(OP_BIT_TO_T, 5'h10, 5'h0, 16'h5000));
    @(negedge clk_in) insn_valid_in = 1'b0;
    chk(25'(flags_out[FLAG_T]), 25'h1);
    li(5'h11, 8'h00);
    run(mk(OP_T_TO_BIT, 5'h11, 5'h0, 16'h3000));
    sd(5'h11, 16'h004c, 8'h08);
    $display("io and program memory test done");
    repeat (3) foreach (sh[i]) begin
      v = 8'($urandom);
      c = 1'($urandom);
      li(5'h11, v);
      run(mk(c ? OP_FLAG_SET : OP_FLAG_CLR, 5'h0, 5'h0, {1'b0, FLAG_C, 12'h0}));
      run(mk(sh[i], 5'h11, 5'h0, 16'h0));
      case (sh[i])
        OP_SHIFT_LEFT: {nc, r} = {v, 1'b0};
        OP_SHIFT_RIGHT: {r, nc} = {1'b0, v};
        OP_SHIFT_RIGHT_S: {r, nc} = {v[7], v};
        OP_ROT_LEFT: {nc, r} = {v, c};
        OP_ROT_RIGHT: {r, nc} = {c, v};
        default: r = {v[3:0], v[7:4]};
      endcase
      @(negedge clk_in) insn_valid_in = 1'b0;
      if (sh[i] != OP_NIB_SWAP)
        chk(25'(flags_out[3:0]), 25'({r[7] ^ nc, r[7], r == 8'h0, nc}));
      sd(5'h11, 16'h0050, r);
    end
    $display("shift test done");
    for (int k = 0; k < 6; k++) begin
      b = op_t'(5'h1 + 5'(k / 2));
      c = k[0];
      o = 7'($urandom);
      run(mk(c ? OP_FLAG_SET : OP_FLAG_CLR, 5'h0, 5'h0,
        {1'b0, (b == OP_BR_NO_OVF) ? FLAG_V : FLAG_I, 12'h0}));
      run(mk(b, 5'h0, 5'h0, {9'h0, o}));
      if (c == (b == OP_BR_IRQ_ON)) pcx = pcx + {{9{o[6]}}, o};
      @(negedge clk_in) insn_valid_in = 1'b0;
      chk(25'(pc_out), 25'(pcx));
    end
    $display("branch test done");
    @(negedge clk_in);
    insn_valid_in = 1'b0;
    repeat (4) @(posedge clk_in);
    chk(25'(exp_q.size()), 25'h0);
    print_verdict();
  end
endmodule // insn_exec_tb
